//--- hdl/iopel_consts.svh
// Register map, field positions, reset values and sizes of the port error log block.
`ifndef IOPEL_CONSTS_SVH
`define IOPEL_CONSTS_SVH

`define IOPEL_AW             14
`define IOPEL_VEC_W          16
`define IOPEL_LEVELS         4
`define IOPEL_PORTS          4
`define IOPEL_LINKS          2
`define IOPEL_CNT_W          3
`define IOPEL_IRQ_W          3

`define IOPEL_OFS_LOG        14'h2040
`define IOPEL_OFS_IRQ_STAT   14'h2044
`define IOPEL_OFS_IRQ_CLR    14'h2048
`define IOPEL_OFS_IRQ_EN     14'h204C
`define IOPEL_OFS_LVL3_ID    14'h2050
`define IOPEL_OFS_VECTOR     14'h2B40

`define IOPEL_EN_BIT         31
`define IOPEL_WND_BIT        29
`define IOPEL_CSRPE_BIT      28
`define IOPEL_CIE_BIT        27
`define IOPEL_ULNK_LSB       25
`define IOPEL_DLNK_LSB       23
`define IOPEL_QOVF_BIT       22
`define IOPEL_BIE_LSB        20
`define IOPEL_PPAR_LSB       16
`define IOPEL_PPKT_LSB       12
`define IOPEL_POVF_LSB       8
`define IOPEL_MBX_LSB        4
`define IOPEL_FLAG_LSB       4
`define IOPEL_FLAG_W         26
`define IOPEL_RSVD_LSB       0
`define IOPEL_RSVD_W         4

`define IOPEL_IRQ_POST_BIT   0
`define IOPEL_IRQ_FAULT_BIT  1
`define IOPEL_IRQ_QOVF_BIT   2

`define IOPEL_WND_DEPTH      3'h4
`define IOPEL_Q_DEPTH        3'h4
`define IOPEL_LOG_RST        32'h0000_0000
`define IOPEL_VEC_RST        16'h0000

`endif

//--- hdl/iopel_pkg.sv
// Types shared by the port error log block.
`include "iopel_consts.svh"

package iopel_pkg;

  // Error reports from the port's own logic, all one-cycle pulses except mbx_pending.
  typedef struct packed {
    logic                      up_link_overflow;
    logic                      up_link_sequence;
    logic                      merge_fifo_over;
    logic                      merge_fifo_under;
    logic                      mbx_queue_over;
    logic                      mbx_queue_under;
    logic                      up_first_cycle_par;
    logic                      csr_parity;
    logic [`IOPEL_LINKS-1:0]   up_link_err;
    logic [`IOPEL_LINKS-1:0]   dn_link_err;
    logic [`IOPEL_LINKS-1:0]   bridge_internal;
    logic [`IOPEL_PORTS-1:0]   port_parity;
    logic [`IOPEL_PORTS-1:0]   port_packet;
    logic [`IOPEL_PORTS-1:0]   port_fifo_ovf;
    logic [`IOPEL_PORTS-1:0]   mbx_status;
    logic [`IOPEL_PORTS-1:0]   mbx_pending;
  } iopel_err_s;

  // Window transactions and interrupt arrivals per priority level.
  typedef struct packed {
    logic                      window_txn;
    logic                      window_decrement;
    logic [`IOPEL_LEVELS-1:0]  intr_arrive;
    logic [`IOPEL_LEVELS-1:0]  intr_taken;
  } iopel_evt_s;

  typedef logic [`IOPEL_CNT_W-1:0] iopel_cnt_t;

  typedef struct packed {
    logic [31:0]                              log;
    logic [`IOPEL_IRQ_W-1:0]                  irq_stat;
    logic [`IOPEL_IRQ_W-1:0]                  irq_en;
    logic [`IOPEL_VEC_W-1:0]                  vector;
    logic                                     armed;
    logic                                     lvl3_pending;
    iopel_cnt_t                               wnd_cnt;
    logic [`IOPEL_LEVELS-1:0][`IOPEL_CNT_W-1:0] q_cnt;
    logic                                     ack;
    logic [31:0]                              rdata;
    logic                                     irq;
    logic                                     err_irq;
    logic                                     fault;
  } iopel_state_s;

endpackage

//--- hdl/iopel_top.sv
// Node error log, error interrupt and fault logic of an I/O port, with an Avalon-MM slave.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "iopel_consts.svh"

module iopel_top
  import iopel_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  // Avalon-MM register slave.
  input  wire logic [`IOPEL_AW-1:0]    address_i,
  input  wire logic                    read_i,
  input  wire logic                    write_i,
  input  wire logic [31:0]             writedata_i,
  input  wire logic [3:0]              byteenable_i,
  output logic      [31:0]             readdata_o,
  output logic                         waitrequest_o,
  // Error and event reports from the port logic.
  input  wire iopel_err_s              err_i,
  input  wire iopel_evt_s              evt_i,
  // Interrupts and system fault.
  output logic                         irq_o,
  output logic                         error_irq_o,
  output logic                         system_fault_line_o
);

  iopel_state_s q;
  iopel_state_s next_q;

  logic [31:0]                 set_v;
  logic [`IOPEL_LEVELS-1:0]    q_ovf;
  logic [`IOPEL_LEVELS-1:0][`IOPEL_CNT_W-1:0] q_next;

  // Each priority level keeps an occupancy count; an untaken arrival at a full level is lost.
  genvar lv;
  generate
    for (lv = 0; lv < `IOPEL_LEVELS; lv++) begin : g_level
      always_comb begin
        // A read in the same cycle frees a slot, so only an untaken arrival at a full level is lost.
        q_ovf[lv]  = evt_i.intr_arrive[lv] && !evt_i.intr_taken[lv]
                     && (q.q_cnt[lv] == `IOPEL_Q_DEPTH);
        q_next[lv] = q.q_cnt[lv];
        if (evt_i.intr_arrive[lv] && !q_ovf[lv] && !evt_i.intr_taken[lv]) begin
          q_next[lv] = q.q_cnt[lv] + 3'h1;
        end else if (!evt_i.intr_arrive[lv] && evt_i.intr_taken[lv] && (q.q_cnt[lv] != 3'h0)) begin
          q_next[lv] = q.q_cnt[lv] - 3'h1;
        end
      end
    end
  endgenerate

  // Events that set error flags this cycle.
  always_comb begin
    set_v = 32'h0000_0000;
    set_v[`IOPEL_WND_BIT]   = evt_i.window_txn && !evt_i.window_decrement
                              && (q.wnd_cnt == `IOPEL_WND_DEPTH);
    set_v[`IOPEL_CSRPE_BIT] = err_i.csr_parity;
    set_v[`IOPEL_CIE_BIT]   = err_i.up_link_overflow | err_i.up_link_sequence
                              | err_i.merge_fifo_over | err_i.merge_fifo_under
                              | err_i.mbx_queue_over | err_i.mbx_queue_under
                              | err_i.up_first_cycle_par;
    set_v[`IOPEL_ULNK_LSB +: `IOPEL_LINKS] = err_i.up_link_err;
    set_v[`IOPEL_DLNK_LSB +: `IOPEL_LINKS] = err_i.dn_link_err;
    set_v[`IOPEL_QOVF_BIT]  = |q_ovf;
    set_v[`IOPEL_BIE_LSB +: `IOPEL_LINKS]  = err_i.bridge_internal;
    set_v[`IOPEL_PPAR_LSB +: `IOPEL_PORTS] = err_i.port_parity;
    set_v[`IOPEL_PPKT_LSB +: `IOPEL_PORTS] = err_i.port_packet;
    set_v[`IOPEL_POVF_LSB +: `IOPEL_PORTS] = err_i.port_fifo_ovf;
    set_v[`IOPEL_MBX_LSB +: `IOPEL_PORTS]  = err_i.mbx_status & ~err_i.mbx_pending;
  end

  logic                        req;
  logic                        wr_go;
  logic                        rd_go;
  logic [31:0]                 clr_v;
  logic [31:0]                 flags_next;
  logic                        any_flag;
  logic                        post;
  logic [`IOPEL_IRQ_W-1:0]     irq_set;
  logic [`IOPEL_IRQ_W-1:0]     irq_clr;
  logic                        full_word;

  always_comb begin
    next_q     = q;
    req        = read_i || write_i;
    // A write or a read side effect happens only at the edge that ends the request.
    wr_go      = write_i && q.ack;
    rd_go      = read_i && q.ack;
    full_word  = &byteenable_i;
    clr_v      = 32'h0000_0000;
    irq_clr    = '0;

    // Answer one cycle after the request is seen, then drop for a cycle.
    next_q.ack = req && !q.ack;
    if (req && !q.ack) begin
      unique case (address_i)
        `IOPEL_OFS_LOG:      next_q.rdata = q.log;
        `IOPEL_OFS_IRQ_STAT: next_q.rdata = {{(32-`IOPEL_IRQ_W){1'b0}}, q.irq_stat};
        `IOPEL_OFS_IRQ_EN:   next_q.rdata = {{(32-`IOPEL_IRQ_W){1'b0}}, q.irq_en};
        `IOPEL_OFS_VECTOR:   next_q.rdata = {{(32-`IOPEL_VEC_W){1'b0}}, q.vector};
        `IOPEL_OFS_LVL3_ID:  next_q.rdata = q.lvl3_pending ? {{(32-`IOPEL_VEC_W){1'b0}}, q.vector}
                                                           : 32'h0000_0000;
        default:             next_q.rdata = 32'h0000_0000;
      endcase
    end

    // Partial writes are ignored so a clear mask is never half applied.
    if (wr_go && full_word) begin
      unique case (address_i)
        `IOPEL_OFS_LOG: begin
          next_q.log[`IOPEL_EN_BIT] = writedata_i[`IOPEL_EN_BIT];
          next_q.log[`IOPEL_RSVD_LSB +: `IOPEL_RSVD_W] = writedata_i[`IOPEL_RSVD_LSB +: `IOPEL_RSVD_W];
          clr_v[`IOPEL_FLAG_LSB +: `IOPEL_FLAG_W] = writedata_i[`IOPEL_FLAG_LSB +: `IOPEL_FLAG_W];
        end
        `IOPEL_OFS_IRQ_CLR: irq_clr = writedata_i[`IOPEL_IRQ_W-1:0];
        `IOPEL_OFS_IRQ_EN:  next_q.irq_en = writedata_i[`IOPEL_IRQ_W-1:0];
        `IOPEL_OFS_VECTOR:  next_q.vector = writedata_i[`IOPEL_VEC_W-1:0];
        default: ;
      endcase
    end

    // A set in the same cycle as its clear wins, so no error is lost.
    flags_next = (q.log & ~clr_v) | set_v;
    next_q.log[`IOPEL_FLAG_LSB +: `IOPEL_FLAG_W] = flags_next[`IOPEL_FLAG_LSB +: `IOPEL_FLAG_W];

    // Bit 30 is unused and reads as zero.
    next_q.log[`IOPEL_EN_BIT-1] = 1'b0;

    any_flag = |q.log[`IOPEL_FLAG_LSB +: `IOPEL_FLAG_W];
    post     = q.log[`IOPEL_EN_BIT] && q.armed && any_flag;
    if (post) begin
      next_q.armed        = 1'b0;
      next_q.lvl3_pending = 1'b1;
    end else if (!(|flags_next[`IOPEL_FLAG_LSB +: `IOPEL_FLAG_W])) begin
      next_q.armed = 1'b1;
    end

    // The level-3 read consumes the pending vector; a new post in that cycle wins.
    if (rd_go && (address_i == `IOPEL_OFS_LVL3_ID) && !post) begin
      next_q.lvl3_pending = 1'b0;
    end

    // The error interrupt stays raised until the processor takes its vector.
    next_q.err_irq = next_q.lvl3_pending;

    if (evt_i.window_txn && !evt_i.window_decrement && (q.wnd_cnt != `IOPEL_WND_DEPTH)) begin
      next_q.wnd_cnt = q.wnd_cnt + 3'h1;
    end else if (!evt_i.window_txn && evt_i.window_decrement && (q.wnd_cnt != 3'h0)) begin
      next_q.wnd_cnt = q.wnd_cnt - 3'h1;
    end
    next_q.q_cnt = q_next;

    next_q.fault = flags_next[`IOPEL_WND_BIT] || flags_next[`IOPEL_CIE_BIT];

    irq_set = '0;
    irq_set[`IOPEL_IRQ_POST_BIT]  = post;
    irq_set[`IOPEL_IRQ_FAULT_BIT] = next_q.fault && !q.fault;
    irq_set[`IOPEL_IRQ_QOVF_BIT]  = set_v[`IOPEL_QOVF_BIT];
    next_q.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_en);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q              <= '0;
      q.log          <= `IOPEL_LOG_RST;
      q.vector       <= `IOPEL_VEC_RST;
      q.armed        <= 1'b1;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign readdata_o          = q.rdata;
  assign waitrequest_o       = !q.ack;
  assign irq_o               = q.irq;
  assign error_irq_o         = q.err_irq;
  assign system_fault_line_o = q.fault;

endmodule

//--- test/iopel_chk_properties.sv
// Concurrent checks on the ports of the port error log block.
`timescale 1ns/1ps
`include "iopel_consts.svh"
module iopel_chk
  import iopel_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic                 mclk_i,
  input wire logic                 rst_n_i,
  input wire logic                 ce_i,
  input wire logic [`IOPEL_AW-1:0] address_i,
  input wire logic                 read_i,
  input wire logic                 write_i,
  input wire logic [31:0]          writedata_i,
  input wire logic [3:0]           byteenable_i,
  input wire logic                 waitrequest_o,
  // Reports and outputs.
  input wire iopel_err_s           err_i,
  input wire iopel_evt_s           evt_i,
  input wire logic                 error_irq_o,
  input wire logic                 system_fault_line_o
);
  logic       en_seen;
  logic       done;
  logic       lvl3;
  logic [2:0] wcnt;
  assign done = ce_i && !waitrequest_o && (read_i || write_i);
  assign lvl3 = done && read_i && address_i == `IOPEL_OFS_LVL3_ID;
  // Shadows of the enable and window count, so posting and overflow can be judged.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      en_seen <= 1'b0;
      wcnt    <= 3'h0;
    end else begin
      if (done && write_i && address_i == `IOPEL_OFS_LOG && byteenable_i == 4'hF) begin
        en_seen <= writedata_i[`IOPEL_EN_BIT];
      end
      if (ce_i && evt_i.window_txn && !evt_i.window_decrement && wcnt != 3'h4) begin
        wcnt <= wcnt + 3'h1;
      end else if (ce_i && evt_i.window_decrement && !evt_i.window_txn && wcnt != 3'h0) begin
        wcnt <= wcnt - 3'h1;
      end
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_FATAL_SETS_FAULT: assert property (ce_i && (|err_i[33:27]) |=> system_fault_line_o)
    else $error("internal control fault did not raise the fault line");
  AST_FAULT_HAS_CAUSE: assert property ($rose(system_fault_line_o) |-> $past(ce_i && (|err_i[33:27] || evt_i.window_txn)))
    else $error("fault line rose with no fatal cause");
  AST_FAULT_STICKY: assert property ($fell(system_fault_line_o) |-> $past(done && write_i && address_i == `IOPEL_OFS_LOG))
    else $error("fault line fell without a log write");
  AST_WND_OVERFLOW: assert property (ce_i && evt_i.window_txn && !evt_i.window_decrement && wcnt == 3'h4 |=> system_fault_line_o)
    else $error("fifth window transaction did not raise the fault line");
  AST_NO_POST_DISABLED: assert property (!en_seen && !error_irq_o |=> !error_irq_o)
    else $error("error interrupt posted while disabled");
  AST_POST_NEEDS_EN: assert property ($rose(error_irq_o) |-> $past(en_seen))
    else $error("error interrupt rose without the global enable");
  AST_LVL3_CLEARS: assert property (lvl3 ##1 ce_i [*2] |-> !error_irq_o)
    else $error("error interrupt stayed after the level-3 read");
  AST_EIRQ_HOLDS: assert property ($fell(error_irq_o) |-> $past(lvl3))
    else $error("error interrupt dropped with no level-3 read");
  cover property ($rose(error_irq_o));
  cover property ($rose(system_fault_line_o));
  cover property (lvl3 && error_irq_o);
endmodule

bind iopel_top iopel_chk u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .waitrequest_o(waitrequest_o),
  .err_i(err_i), .evt_i(evt_i), .error_irq_o(error_irq_o), .system_fault_line_o(system_fault_line_o)
);

//--- test/iopel_src.sv
// Port-logic model that sends one-cycle error reports into the block.
`timescale 1ns/1ps
module iopel_src
  import iopel_pkg::*;
(
  // Clock and request from the bench.
  input  wire logic       mclk_i,
  input  wire logic       fire_i,
  input  wire logic [5:0] sel_i,
  input  wire logic [3:0] pend_i,
  // Reports into the block.
  output iopel_err_s      err_o
);
  initial err_o = '0;
  // Reports other than mbx_pending last one cycle only, so a block that counts a held level twice is caught.
  always @(posedge mclk_i) begin
    err_o <= iopel_err_s'({30'h0, pend_i} | (fire_i ? (34'h1 << sel_i) : 34'h0));
  end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the port error log block.
`timescale 1ns/1ps
`include "iopel_consts.svh"
module tb_top;
  import iopel_pkg::*;
  logic                 mclk_i = 1'b0;
  logic                 rst_n_i = 1'b0;
  logic                 rd = 1'b0;
  logic                 wr = 1'b0;
  logic                 fire = 1'b0;
  logic                 ce = 1'b1;
  logic [5:0]           sel = '0;
  logic [3:0]           pend = '0;
  logic [`IOPEL_AW-1:0] addr = '0;
  logic [31:0]          wd = '0;
  logic [31:0]          rdata;
  logic                 wait_o;
  logic                 irq;
  logic                 eirq;
  logic                 fault;
  iopel_err_s           err;
  iopel_evt_s           evt = '0;
  logic [31:0]          exp_q[$];
  logic [31:0]          seed = 32'h8574;
  logic [31:0]          v;
  int                   fail_count = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  iopel_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .address_i(addr), .read_i(rd),
    .write_i(wr), .writedata_i(wd), .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wait_o),
    .err_i(err), .evt_i(evt), .irq_o(irq), .error_irq_o(eirq), .system_fault_line_o(fault));
  iopel_src u_src (.mclk_i(mclk_i), .fire_i(fire), .sel_i(sel), .pend_i(pend), .err_o(err));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Report bit for each report index; the link groups sit one place higher, csr_parity goes to bit 28 and the control faults all share bit 27.
  function automatic int lb(input int s);
    if (s == 26) return 28;
    if (s > 26) return 27;
    return (s > 21) ? s + 1 : s;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic r, input logic [13:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    if (r) exp_q.push_back(d);
    rd <= r;
    wr <= !r;
    addr <= a;
    if (!r) wd <= d;
    // Waitrequest is sampled at the rising edge; the transfer ends at the first edge that sees it low.
    do @(posedge mclk_i); while (wait_o !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic inj(input logic [5:0] s);
    @(posedge mclk_i);
    fire <= 1'b1;
    sel <= s;
    @(posedge mclk_i);
    fire <= 1'b0;
  endtask
  task automatic ev(input logic [9:0] e, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      evt <= e;
      @(posedge mclk_i);
      evt <= '0;
    end
  endtask
  // Read data are judged at the answer edge, oldest expectation first.
  always @(posedge mclk_i) begin
    if (rst_n_i && rd && wait_o === 1'b0) chk("readdata", exp_q.pop_front(), rdata);
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(1, `IOPEL_OFS_LOG, `IOPEL_LOG_RST);
    v = rnd() & 32'h0000_FFFF;
    bus(0, `IOPEL_OFS_VECTOR, v);
    bus(1, `IOPEL_OFS_VECTOR, v);
    for (int s = 4; s < 34; s++) begin
      inj(s[5:0]);
      bus(0, `IOPEL_OFS_LOG, ~(32'h1 << lb(s)) & 32'h3FFF_FFF0);
      bus(1, `IOPEL_OFS_LOG, 32'h1 << lb(s));
      @(negedge mclk_i);
      chk("fault", lb(s) == 27, fault);
      chk("eirq", 0, eirq);
      bus(0, `IOPEL_OFS_LOG, 32'h1 << lb(s));
      bus(1, `IOPEL_OFS_LOG, 32'h0);
    end
    inj(6'd24);
    bus(1, `IOPEL_OFS_LOG, 32'h0200_0000);
    // Software answers a link error by resetting the port; the log and the interrupt status must come back clean.
    rst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(1, `IOPEL_OFS_LOG, `IOPEL_LOG_RST);
    bus(1, `IOPEL_OFS_IRQ_STAT, 32'h0);
    bus(0, `IOPEL_OFS_VECTOR, v);
    // A report that arrives while the clock enable is low must be lost.
    ce <= 1'b0;
    inj(6'd27);
    @(posedge mclk_i);
    ce <= 1'b1;
    bus(1, `IOPEL_OFS_LOG, 32'h0);
    pend <= 4'hF;
    inj(6'd4);
    bus(1, `IOPEL_OFS_LOG, 32'h0);
    pend <= 4'h0;
    ev(10'h200, 4);
    ev(10'h100, 1);
    ev(10'h200, 1);
    bus(1, `IOPEL_OFS_LOG, 32'h0);
    ev(10'h200, 1);
    bus(1, `IOPEL_OFS_LOG, 32'h2000_0000);
    @(negedge mclk_i);
    chk("fault", 1, fault);
    bus(0, `IOPEL_OFS_LOG, 32'h2000_0000);
    ev(10'h040, 5);
    bus(1, `IOPEL_OFS_LOG, 32'h0040_0000);
    bus(1, `IOPEL_OFS_IRQ_STAT, 32'h6);
    bus(0, `IOPEL_OFS_LOG, 32'h0040_0000);
    bus(0, `IOPEL_OFS_IRQ_CLR, 32'h7);
    bus(0, `IOPEL_OFS_LOG, 32'h8000_0000);
    inj(6'd26);
    bus(1, `IOPEL_OFS_LOG, 32'h9000_0000);
    bus(1, `IOPEL_OFS_IRQ_STAT, 32'h1);
    chk("irq", 0, irq);
    bus(0, `IOPEL_OFS_IRQ_EN, 32'h1);
    repeat (2) @(negedge mclk_i);
    chk("irq", 1, irq);
    chk("eirq", 1, eirq);
    bus(1, `IOPEL_OFS_LVL3_ID, v);
    inj(6'd16);
    repeat (4) @(negedge mclk_i);
    chk("eirq", 0, eirq);
    bus(0, `IOPEL_OFS_LOG, 32'hBFFF_FFF0);
    inj(6'd16);
    bus(1, `IOPEL_OFS_LOG, 32'h8001_0000);
    @(negedge mclk_i);
    chk("eirq", 1, eirq);
    bus(0, `IOPEL_OFS_IRQ_CLR, 32'h7);
    repeat (2) @(negedge mclk_i);
    chk("irq", 0, irq);
    bus(1, 14'h2060, 32'h0);
    wrap_up();
  end
endmodule
